// ==== logic/lse_pkg.sv ====
// package: opcodes, field positions, flag bits and reset values for the subtract unit
package lse_pkg;
  localparam int unsigned DW       = 8;
  localparam logic [7:0]  OPC_SUBL = 8'h08;   // 0000 1000 kkkk kkkk
  localparam logic [5:0]  OPC_SUBF = 6'h17;   // 0101 11da ffff ffff
  localparam int unsigned OPC_HI   = 15;
  localparam int unsigned OPC_LO8  = 8;
  localparam int unsigned OPC_LO6  = 10;
  localparam int unsigned DEST_BIT = 9;
  localparam int unsigned ACC_BIT  = 8;
  localparam int unsigned NIB      = 4;
  // flag vector layout {n, ov, z, dc, c}
  localparam int unsigned FLG_C  = 0;
  localparam int unsigned FLG_DC = 1;
  localparam int unsigned FLG_Z  = 2;
  localparam int unsigned FLG_OV = 3;
  localparam int unsigned FLG_N  = 4;
  localparam int unsigned FLG_W  = 5;
  localparam logic [7:0]  W_RST   = 8'h00;
  localparam logic [4:0]  FLG_RST = 5'h00;
  typedef enum logic [1:0] {LSE_OP_NONE, LSE_OP_LIT, LSE_OP_FILE} lse_op_t;
  typedef enum logic [1:0] {LSE_Q1, LSE_Q2, LSE_Q3, LSE_Q4} lse_phase_t;
endpackage

// ==== logic/lse_alu_if.sv ====
// interface: operands and results passed between sequencer and subtractor
`timescale 1ns/100ps
interface lse_alu_if;
  logic [7:0] minuend;
  logic [7:0] subtrahend;
  logic [7:0] diff;
  logic [4:0] flags;
  modport seq (output minuend, output subtrahend, input diff, input flags);
  modport alu (input minuend, input subtrahend, output diff, output flags);
endinterface

// ==== logic/lse_sub.sv ====
// module: combinational 8-bit subtractor with status flags
`timescale 1ns/100ps
module lse_sub
(
  lse_alu_if.alu alu
);
  logic [8:0] full;
  logic [4:0] low;
  logic       ov;

  always_comb
  begin
    // carry out of a + ~b + 1 is set when no borrow occurs
    full = {1'b0, alu.minuend} + {1'b0, ~alu.subtrahend} + 9'h001;
    low  = {1'b0, alu.minuend[lse_pkg::NIB-1:0]}
         + {1'b0, ~alu.subtrahend[lse_pkg::NIB-1:0]} + 5'h01;
    ov   = (alu.minuend[7] != alu.subtrahend[7])
         && (full[7] != alu.minuend[7]);
    alu.diff                      = full[7:0];
    alu.flags                     = lse_pkg::FLG_RST;
    alu.flags[lse_pkg::FLG_C]     = full[8];
    alu.flags[lse_pkg::FLG_DC]    = low[lse_pkg::NIB];
    alu.flags[lse_pkg::FLG_Z]     = (full[7:0] == 8'h00);
    alu.flags[lse_pkg::FLG_OV]    = ov;
    alu.flags[lse_pkg::FLG_N]     = full[7];
  end
endmodule // lse_sub

// ==== logic/lse_core.sv ====
// module: literal-subtract execution datapath with four-phase sequencing
//
// Behaviour
// - the literal operand minus the working register is formed in two's complement.
// - the literal subtract writes only the working register, never a file register.
// - opcode 0000 1000 kkkk kkkk is decoded and finishes within one instruction cycle.
// - decode in phase one, literal fetch in two, compute in three, write in four.
// - literal above working value sets carry and clears zero; negative follows bit 7 of the difference.
// - equal operands give zero with zero and carry set and negative clear.
// - literal below working value clears carry, negative follows bit 7, keeps the wrapped value.
// - a negative difference is kept as an 8-bit two's-complement value.
`timescale 1ns/100ps
module lse_core
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // instruction and file operand
  input  wire logic [15:0] instr_i,
  input  wire logic [7:0]  file_data_i,
  // file write-back
  output logic             file_we_o,
  output logic [7:0]       file_addr_o,
  output logic             file_access_bank_o,
  output logic [7:0]       file_wdata_o,
  // state
  output logic [7:0]       w_o,
  output logic [4:0]       flags_o,
  output logic [1:0]       phase_o,
  output logic             done_o
);
  lse_alu_if              alu_bus ();
  lse_pkg::lse_phase_t    phase_reg;
  lse_pkg::lse_op_t       op_reg;
  logic                   dest_reg;
  logic [7:0]             addr_reg;
  logic                   acc_reg;
  logic [7:0]             a_reg;
  logic [7:0]             b_reg;
  logic [7:0]             res_reg;
  logic [4:0]             rflg_reg;
  logic [7:0]             w_reg;
  logic [4:0]             flg_reg;
  logic                   fwe_reg;
  logic                   done_reg;

  lse_sub u_sub
  (
    .alu (alu_bus)
  );

  assign alu_bus.minuend    = a_reg;
  assign alu_bus.subtrahend = b_reg;

  // phase counter Q1..Q4
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      phase_reg <= lse_pkg::LSE_Q1;
    else if (ce_i)
    begin
      unique case (phase_reg)
        lse_pkg::LSE_Q1: phase_reg <= lse_pkg::LSE_Q2;
        lse_pkg::LSE_Q2: phase_reg <= lse_pkg::LSE_Q3;
        lse_pkg::LSE_Q3: phase_reg <= lse_pkg::LSE_Q4;
        lse_pkg::LSE_Q4: phase_reg <= lse_pkg::LSE_Q1;
      endcase
    end
  end

  // decode in Q1
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      op_reg   <= lse_pkg::LSE_OP_NONE;
      dest_reg <= 1'b0;
      addr_reg <= 8'h00;
      acc_reg  <= 1'b0;
    end
    else if (ce_i && phase_reg == lse_pkg::LSE_Q1)
    begin
      dest_reg <= instr_i[lse_pkg::DEST_BIT];
      acc_reg  <= instr_i[lse_pkg::ACC_BIT];
      addr_reg <= instr_i[7:0];
      if (instr_i[lse_pkg::OPC_HI:lse_pkg::OPC_LO8] == lse_pkg::OPC_SUBL)
        op_reg <= lse_pkg::LSE_OP_LIT;
      else if (instr_i[lse_pkg::OPC_HI:lse_pkg::OPC_LO6]
               == lse_pkg::OPC_SUBF)
        op_reg <= lse_pkg::LSE_OP_FILE;
      else
        op_reg <= lse_pkg::LSE_OP_NONE;
    end
  end

  // operand fetch in Q2: literal or file as minuend, w as subtrahend
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      a_reg <= 8'h00;
      b_reg <= 8'h00;
    end
    else if (ce_i && phase_reg == lse_pkg::LSE_Q2)
    begin
      a_reg <= (op_reg == lse_pkg::LSE_OP_FILE) ? file_data_i : addr_reg;
      b_reg <= w_reg;
    end
  end

  // compute in Q3
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      res_reg  <= 8'h00;
      rflg_reg <= lse_pkg::FLG_RST;
    end
    else if (ce_i && phase_reg == lse_pkg::LSE_Q3)
    begin
      res_reg  <= alu_bus.diff;
      rflg_reg <= alu_bus.flags;
    end
  end

  // write-back in Q4
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      w_reg    <= lse_pkg::W_RST;
      flg_reg  <= lse_pkg::FLG_RST;
      fwe_reg  <= 1'b0;
      done_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      fwe_reg  <= 1'b0;
      done_reg <= 1'b0;
      if (phase_reg == lse_pkg::LSE_Q4 && op_reg != lse_pkg::LSE_OP_NONE)
      begin
        done_reg <= 1'b1;
        if (op_reg == lse_pkg::LSE_OP_LIT)
          flg_reg <= rflg_reg;
        else
        begin
          // file form touches n, ov, c only
          flg_reg[lse_pkg::FLG_N]  <= rflg_reg[lse_pkg::FLG_N];
          flg_reg[lse_pkg::FLG_OV] <= rflg_reg[lse_pkg::FLG_OV];
          flg_reg[lse_pkg::FLG_C]  <= rflg_reg[lse_pkg::FLG_C];
        end
        if (op_reg == lse_pkg::LSE_OP_FILE && dest_reg)
          fwe_reg <= 1'b1;
        else
          w_reg <= res_reg;
      end
    end
  end

  // a one-cycle pulse only when ce_i is high next; hold while frozen
  assign file_we_o          = fwe_reg & ce_i;
  assign file_addr_o        = addr_reg;
  assign file_access_bank_o = acc_reg;
  assign file_wdata_o       = res_reg;
  assign w_o                = w_reg;
  assign flags_o            = flg_reg;
  assign phase_o            = phase_reg;
  assign done_o             = done_reg & ce_i;

  chk_lit_writes_w: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && phase_reg == lse_pkg::LSE_Q4 && op_reg == lse_pkg::LSE_OP_LIT
    |=> w_reg == $past(res_reg) && !fwe_reg)
    else $error("literal subtract did not write w");

  chk_sub_value: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && phase_reg == lse_pkg::LSE_Q3
    |=> res_reg == 8'($past(a_reg) - $past(b_reg)))
    else $error("difference wrong");

  chk_carry_gt: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && phase_reg == lse_pkg::LSE_Q3 && a_reg > b_reg
    |=> rflg_reg[lse_pkg::FLG_C] && !rflg_reg[lse_pkg::FLG_Z])
    else $error("carry or zero wrong for larger literal");

  chk_zero_eq: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && phase_reg == lse_pkg::LSE_Q3 && a_reg == b_reg
    |=> rflg_reg[lse_pkg::FLG_Z] && rflg_reg[lse_pkg::FLG_C]
        && !rflg_reg[lse_pkg::FLG_N])
    else $error("flags wrong for equal operands");

  chk_borrow_lt: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && phase_reg == lse_pkg::LSE_Q3 && a_reg < b_reg
    |=> !rflg_reg[lse_pkg::FLG_C] && !rflg_reg[lse_pkg::FLG_Z])
    else $error("borrow not flagged");

  chk_wrap_ff: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && phase_reg == lse_pkg::LSE_Q3 && a_reg == 8'h02 && b_reg == 8'h03
    |=> res_reg == 8'hFF && rflg_reg[lse_pkg::FLG_N])
    else $error("two's complement wrap wrong");

  chk_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && phase_reg == lse_pkg::LSE_Q1
    && instr_i[lse_pkg::OPC_HI:lse_pkg::OPC_LO8] == lse_pkg::OPC_SUBL
    ##1 ce_i [*4] |-> done_reg)
    else $error("literal subtract not done in one cycle");

  chk_phase_order: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && phase_reg == lse_pkg::LSE_Q2 |=> phase_reg == lse_pkg::LSE_Q3)
    else $error("phase order broken");

  chk_file_dest: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && phase_reg == lse_pkg::LSE_Q4 && op_reg == lse_pkg::LSE_OP_FILE
    && dest_reg |=> fwe_reg && $stable(w_reg))
    else $error("file subtract destination wrong");

  // the file form must leave zero and digit carry as they were
  chk_file_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && phase_reg == lse_pkg::LSE_Q4 && op_reg == lse_pkg::LSE_OP_FILE
    |=> $stable(flg_reg[lse_pkg::FLG_Z]) && $stable(flg_reg[lse_pkg::FLG_DC]))
    else $error("file subtract touched zero or digit carry");

  // unknown words run through the phases but retire nothing
  chk_none_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && phase_reg == lse_pkg::LSE_Q4 && op_reg == lse_pkg::LSE_OP_NONE
    |=> !done_reg && !fwe_reg && $stable(w_reg) && $stable(flg_reg))
    else $error("unknown opcode changed state");

  chk_frozen_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(phase_reg) && $stable(w_reg) && $stable(flg_reg))
    else $error("state moved while clock enable low");
endmodule // lse_core

// ==== test/tb.sv ====
// testbench: self-checking literal and file subtract sequences
`timescale 1ns/100ps
module tb;
  typedef struct {
    logic [7:0] w;
    logic [4:0] f;
    logic       we;
    logic [7:0] wd;
    logic [8:0] fa;
  } lse_exp_t;
  logic        clk_i;
  logic        rst_i;
  logic        ce_i;
  logic [15:0] instr_i;
  logic [7:0]  file_data_i;
  logic        file_we_o;
  logic [7:0]  file_addr_o;
  logic        file_access_bank_o;
  logic [7:0]  file_wdata_o;
  logic [7:0]  w_o;
  logic [4:0]  flags_o;
  logic [1:0]  phase_o;
  logic        done_o;
  lse_exp_t    q[$];
  lse_exp_t    e_obs;
  logic [7:0]  w_m;
  logic [4:0]  f_m;
  int          err_total;
  int          compares;
  int          cyc;
  lse_core dut (
    .clk_i              (clk_i),
    .rst_i              (rst_i),
    .ce_i               (ce_i),
    .instr_i            (instr_i),
    .file_data_i        (file_data_i),
    .file_we_o          (file_we_o),
    .file_addr_o        (file_addr_o),
    .file_access_bank_o (file_access_bank_o),
    .file_wdata_o       (file_wdata_o),
    .w_o                (w_o),
    .flags_o            (flags_o),
    .phase_o            (phase_o),
    .done_o             (done_o)
  );
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("counts: compares=%0d mismatches=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // model the result, queue it, then hold the word for four enabled edges
  task automatic issue(input logic [15:0] ins, input logic [7:0] fd);
    logic [7:0] a;
    logic [7:0] d;
    lse_exp_t   e;
    logic       lit;
    logic       fil;
    int         n;
    lit = (ins[15:8] == lse_pkg::OPC_SUBL);
    fil = (ins[15:10] == lse_pkg::OPC_SUBF);
    a = lit ? ins[7:0] : fd;
    d = a - w_m;
    e.f = f_m;
    e.f[lse_pkg::FLG_C] = (a >= w_m);
    e.f[lse_pkg::FLG_OV] = (a[7] ^ w_m[7]) & (d[7] ^ a[7]);
    e.f[lse_pkg::FLG_N] = d[7];
    if (lit)
    begin
      e.f[lse_pkg::FLG_DC] = (a[3:0] >= w_m[3:0]);
      e.f[lse_pkg::FLG_Z] = (d == 8'h00);
    end
    e.we = fil & ins[lse_pkg::DEST_BIT];
    e.wd = d;
    e.fa = ins[8:0];
    e.w = e.we ? w_m : d;
    if (lit | fil)
    begin
      w_m = e.w;
      f_m = e.f;
      q.push_back(e);
    end
    instr_i = ins;
    file_data_i = fd;
    n = 0;
    // random stalls: a frozen cycle must not count as a phase
    while (n < 4)
    begin
      ce_i = ($urandom % 4) != 0;
      @(posedge clk_i);
      if (ce_i)
        n++;
      #1;
    end
  endtask
  always @(negedge clk_i)
    if (!rst_i && (done_o === 1'b1 || file_we_o === 1'b1))
    begin
      if (q.size() == 0)
        chk(16'h0001, 16'h0000);
      else
      begin
        e_obs = q.pop_front();
        chk(w_o, e_obs.w);
        chk(phase_o, 16'(lse_pkg::LSE_Q1));
        chk(flags_o, e_obs.f);
        chk(file_we_o, e_obs.we);
        if (e_obs.we)
        begin
          chk(file_wdata_o, e_obs.wd);
          chk({file_access_bank_o, file_addr_o}, e_obs.fa);
        end
      end
    end
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      results();
    end
  end
  initial
  begin
    rst_i = 1'b1;
    ce_i = 1'b0;
    instr_i = 16'h0000;
    file_data_i = 8'h00;
    w_m = lse_pkg::W_RST;
    f_m = lse_pkg::FLG_RST;
    void'($urandom(64));
    repeat (10) @(posedge clk_i);
    #1;
    chk(w_o, lse_pkg::W_RST);
    chk(flags_o, lse_pkg::FLG_RST);
    chk(phase_o, 16'(lse_pkg::LSE_Q1));
    rst_i = 1'b0;
    // literal above, equal to and below the working value
    issue(16'h0801, 8'h00);
    issue(16'h0802, 8'h00);
    issue(16'h0803, 8'h00);
    issue(16'h0802, 8'h00);
    issue(16'h0803, 8'h00);
    issue(16'h0802, 8'h00);
    issue(16'h08FF, 8'h00);
    $display("test directed done");
    repeat (60)
    begin
      case ($urandom % 4)
        0: issue({8'h08, 8'($urandom)}, 8'($urandom));
        1: issue({6'h17, 10'($urandom)}, 8'($urandom));
        2: issue({8'h0F, 8'($urandom)}, 8'($urandom));
        default: issue({8'h08, 8'($urandom % 2 ? 8'hFF : 8'h00)}, 8'h00);
      endcase
    end
    $display("test random done");
    ce_i = 1'b1;
    repeat (6) @(posedge clk_i);
    chk(16'(q.size()), 16'h0000);
    results();
  end
endmodule // tb
